// >>> rtl/dbg_clock_sync.sv
// Purpose: test clock handshake, debug state and test access port controller
// Assumes: agent holds tms/tdi and the next test clock edge until the echo returns
// Notes: the test clock is both a capture clock and a level brought across
//
// Functional notes
// - core reset low clears debug state silently, debugger not told
// - test clock passes three register stages before any edge is used
// - agent drives a test clock edge; device echoes it once synchronised
// - debug port follows the boundary-scan access port and controller states
// - debug acknowledge tells the system the core is in debug state
// - debug permit low ignores request and break, forces acknowledge low
// - one clock, qualified by memory enable and separate debug enable
`timescale 1ns/1ns
module dbg_clock_sync (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic external_debug_request_i,
	input wire logic external_break_input_i,
	input wire logic debug_permit_input_i,
	input wire logic core_rst_n_i,
	input wire logic memory_clock_qualifier_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic returned_test_clock_o,
	output logic debug_clock_qualifier_o,
	output logic core_clock_enable_o,
	output logic debug_acknowledge_o
);
	import dbg_sync_pkg::*;

	link_sample_s link_q;
	link_sample_s link_d;
	core_state_s st_q;
	core_state_s st_d;
	pin_s pins_raw;
	pin_s pins_s;
	logic returned_test_clock;
	logic rise;
	logic fall;
	logic restart_evt;
	logic [IR_WIDTH-1:0] ir_live;

	// next controller state from tms
	function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
		case (s)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	// link side: sample tms/tdi on the agent's own rising edge
	always_comb begin
		link_d.tms = tms_i;
		link_d.tdi = tdi_i;
	end

	// samples stay put until the next edge, which the agent withholds until echo
	always_ff @(posedge tck_i or posedge rst_i) begin
		if (rst_i) begin
			link_q <= LINK_RESET;
		end else begin
			link_q <= link_d;
		end
	end

	// test clock level into the core domain
	sync_chain #(
		.WIDTH(1),
		.STAGES(TCK_SYNC_STAGES),
		.RESET_VAL(1'h0)
	) u_tck_sync (
		.clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(tck_i),
		.q_o(returned_test_clock)
	);

	// system debug pins are asynchronous to the core clock
	assign pins_raw = '{debug_request: external_debug_request_i, break_in: external_break_input_i,
		permit: debug_permit_input_i, core_rst_n: core_rst_n_i};

	sync_chain #(
		.WIDTH($bits(pin_s)),
		.STAGES(PIN_SYNC_STAGES),
		.RESET_VAL(PIN_RESET)
	) u_pin_sync (
		.clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	// edges of the synchronised test clock
	assign rise = returned_test_clock & ~st_q.returned_test_clock_prev;
	assign fall = ~returned_test_clock & st_q.returned_test_clock_prev;
	// instruction in force; update-ir loads on the edge that leaves it, so look ahead there
	assign ir_live = (st_q.tap == TAP_UPD_IR) ? st_q.ir_shift : st_q.ir;
	// restart taken when the controller lands in idle holding the restart code
	assign restart_evt = rise && st_q.tap != TAP_IDLE && tap_next(st_q.tap, link_q.tms) == TAP_IDLE
		&& ir_live == IR_RESTART;

	// core-side next state
	always_comb begin
		st_d = st_q;
		st_d.returned_test_clock_prev = returned_test_clock;
		st_d.dbg_qual = rise;
		if (rise) begin
			case (st_q.tap)
				TAP_RESET: st_d.ir = IR_BYPASS;
				TAP_CAP_IR: st_d.ir_shift = IR_CAPTURE;
				TAP_SHIFT_IR: st_d.ir_shift = {link_q.tdi, st_q.ir_shift[IR_WIDTH-1:1]};
				TAP_UPD_IR: st_d.ir = st_q.ir_shift;
				TAP_CAP_DR: st_d.bypass = BYPASS_CAPTURE;
				TAP_SHIFT_DR: st_d.bypass = link_q.tdi;
				default: st_d.bypass = st_q.bypass;
			endcase
			st_d.tap = tap_next(st_q.tap, link_q.tms);
		end
		// output changes on the falling test clock as the standard expects
		if (fall) begin
			st_d.tdo_oe = (st_q.tap == TAP_SHIFT_IR) || (st_q.tap == TAP_SHIFT_DR);
			if (st_q.tap == TAP_SHIFT_IR) begin
				st_d.tdo = st_q.ir_shift[0];
			end else if (st_q.tap == TAP_SHIFT_DR) begin
				st_d.tdo = st_q.bypass;
			end
		end
		// debug state; core reset wins silently
		if (!pins_s.core_rst_n) begin
			st_d.in_debug = 1'h0;
		end else if (st_q.in_debug && restart_evt) begin
			st_d.in_debug = 1'h0;
		end else if (!st_q.in_debug && pins_s.permit && (pins_s.debug_request || pins_s.break_in)) begin
			st_d.in_debug = 1'h1;
		end
		st_d.ack = st_d.in_debug & pins_s.permit;
		// in debug the core steps only on rising test clock edges
		st_d.core_ce = st_d.in_debug ? rise : memory_clock_qualifier_i;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= CORE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// every output is a flop; the echo is the last synchroniser stage
	assign returned_test_clock_o = returned_test_clock;
	assign tdo_o = st_q.tdo;
	assign tdo_oe_o = st_q.tdo_oe;
	assign debug_clock_qualifier_o = st_q.dbg_qual;
	assign core_clock_enable_o = st_q.core_ce;
	assign debug_acknowledge_o = st_q.ack;

	// checks on the core clock
	property p_ack_permit;
		@(posedge sys_clk_i) disable iff (rst_i)
		!pins_s.permit |=> !debug_acknowledge_o;
	endproperty
	a_ack_permit: assert property (p_ack_permit) else $error("acknowledge high without permit");

	property p_ack_cause;
		@(posedge sys_clk_i) disable iff (rst_i)
		$rose(debug_acknowledge_o) |-> ($past(pins_s.debug_request) || $past(pins_s.break_in) || $past(st_q.in_debug));
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("acknowledge rose with no cause");

	property p_ack_hold;
		@(posedge sys_clk_i) disable iff (rst_i)
		debug_acknowledge_o && pins_s.permit && pins_s.core_rst_n && !restart_evt |=> debug_acknowledge_o;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped inside debug");

	property p_core_reset;
		@(posedge sys_clk_i) disable iff (rst_i)
		!pins_s.core_rst_n |=> !debug_acknowledge_o ##1 (!debug_acknowledge_o || $past(pins_s.core_rst_n));
	endproperty
	a_core_reset: assert property (p_core_reset) else $error("debug survived core reset");

	property p_echo_qual;
		@(posedge sys_clk_i) disable iff (rst_i)
		$rose(returned_test_clock_o) |=> debug_clock_qualifier_o ##1 !debug_clock_qualifier_o;
	endproperty
	a_echo_qual: assert property (p_echo_qual) else $error("qualifier not one cycle after echo");

	property p_qual_only_on_echo;
		@(posedge sys_clk_i) disable iff (rst_i)
		debug_clock_qualifier_o |-> $past(returned_test_clock_o) && !$past(returned_test_clock_o, 2);
	endproperty
	a_qual_only_on_echo: assert property (p_qual_only_on_echo) else $error("qualifier without echo edge");

	property p_ce_debug;
		@(posedge sys_clk_i) disable iff (rst_i)
		debug_acknowledge_o |-> core_clock_enable_o == debug_clock_qualifier_o;
	endproperty
	a_ce_debug: assert property (p_ce_debug) else $error("core enable not debug qualified");

	property p_tap_update;
		@(posedge sys_clk_i) disable iff (rst_i)
		rise && st_q.tap == TAP_UPD_IR && !link_q.tms |=> st_q.tap == TAP_IDLE && st_q.ir == $past(st_q.ir_shift);
	endproperty
	a_tap_update: assert property (p_tap_update) else $error("update-ir did not load and idle");

	c_enter: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(debug_acknowledge_o));
	c_restart: cover property (@(posedge sys_clk_i) disable iff (rst_i) restart_evt && st_q.in_debug);
	c_shift_ir: cover property (@(posedge sys_clk_i) disable iff (rst_i) rise && st_q.tap == TAP_SHIFT_IR);
endmodule

// >>> include/dbg_sync_pkg.sv
// Purpose: shared constants and types for the debug clock handshake block
// Assumes: one core clock plus an off-chip test clock that the agent paces
// Notes: instruction codes are plain defaults, not tied to any product
package dbg_sync_pkg;

	// synchroniser depths
	localparam int TCK_SYNC_STAGES = 3;
	localparam int PIN_SYNC_STAGES = 2;

	// instruction register layout and codes
	localparam int IR_WIDTH = 4;
	localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_WIDTH-1:0] IR_RESTART = 4'h4;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
	localparam logic BYPASS_CAPTURE = 1'h0;

	// test access port controller states
	typedef enum logic [3:0] {
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} tap_state_e;

	// values sampled on the rising test clock
	typedef struct packed {
		logic tms;
		logic tdi;
	} link_sample_s;

	// debug pins from the surrounding system
	typedef struct packed {
		logic debug_request;
		logic break_in;
		logic permit;
		logic core_rst_n;
	} pin_s;

	// whole state of the core-clock side
	typedef struct packed {
		tap_state_e tap;
		logic [IR_WIDTH-1:0] ir;
		logic [IR_WIDTH-1:0] ir_shift;
		logic bypass;
		logic tdo;
		logic tdo_oe;
		logic returned_test_clock_prev;
		logic in_debug;
		logic ack;
		logic dbg_qual;
		logic core_ce;
	} core_state_s;

	localparam link_sample_s LINK_RESET = '{tms: 1'h1, tdi: 1'h0};
	localparam pin_s PIN_RESET = '{debug_request: 1'h0, break_in: 1'h0, permit: 1'h0, core_rst_n: 1'h0};
	localparam core_state_s CORE_RESET = '{
		tap: TAP_RESET, ir: IR_BYPASS, ir_shift: 4'h0, bypass: 1'h0, tdo: 1'h0, tdo_oe: 1'h0,
		returned_test_clock_prev: 1'h0, in_debug: 1'h0, ack: 1'h0, dbg_qual: 1'h0, core_ce: 1'h0};

endpackage

// >>> rtl/sync_chain.sv
// Purpose: multi-stage flip-flop synchroniser for levels
// Assumes: input is quasi-static relative to STAGES clock periods
// Notes: only the last stage may be read by downstream logic
`timescale 1ns/1ns
module sync_chain #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [STAGES-1:0][WIDTH-1:0] chain_q;
	logic [STAGES-1:0][WIDTH-1:0] chain_d;

	// shift toward the output stage
	always_comb begin
		chain_d = {chain_q[STAGES-2:0], d_i};
	end

	// async reset loads the idle value into every stage, so no false edge follows release
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			chain_q <= {STAGES{RESET_VAL}};
		end else begin
			chain_q <= chain_d;
		end
	end

	assign q_o = chain_q[STAGES-1];
endmodule

// >>> dv/tck_agent.sv
// Purpose: off-chip debug agent pacing the test clock by its echo
// Assumes: 160 ns link clock, phase unrelated to the core clock
// Notes: tck stands still between steps; tdi inverts once sampled
`timescale 1ns/1ns
module tck_agent (
	input wire logic sys_clk_i,
	input wire logic returned_test_clock_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	logic link_clk = 1'h0;
	initial begin
		tck_o = 1'h0;
		tms_o = 1'h1;
		tdi_o = 1'h0;
	end
	// odd offset keeps link edges clear of core edges
	initial begin
		#37;
		forever #80 link_clk = ~link_clk;
	end
	// core cycles until the echo shows the level
	task automatic wait_echo(input logic lvl, output int n);
		n = 0;
		while (returned_test_clock_i !== lvl && n < 20) begin
			@(posedge sys_clk_i);
			#2;
			n++;
		end
	endtask
	// one test clock period, each edge held until echoed
	task automatic step(input logic tms_v, input logic tdi_v, output int lat);
		int n;
		@(posedge link_clk);
		tms_o <= tms_v;
		tdi_o <= tdi_v;
		@(posedge link_clk);
		tck_o <= 1'h1;
		#1;
		wait_echo(1'h1, lat);
		tdi_o <= ~tdi_v;
		@(posedge link_clk);
		tck_o <= 1'h0;
		#1;
		wait_echo(1'h0, n);
		// tdo lands one core cycle after the falling echo
		@(posedge sys_clk_i);
		#2;
	endtask
endmodule

// >>> dv/debug_clock_sync_handshake_bench.sv
// Purpose: self-checking bench for the debug clock handshake block
// Assumes: agent model drives the test port
// Notes: pins change 2 ns after the core clock edge
`timescale 1ns/1ns
module debug_clock_sync_handshake_bench;
	import dbg_sync_pkg::*;
	logic sys_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic tck_i;
	logic tms_i;
	logic tdi_i;
	logic req = 1'h0;
	logic brk = 1'h0;
	logic permit = 1'h1;
	logic core_rst_n = 1'h1;
	logic memq = 1'h0;
	logic tdo, oe, echo, qual, ce, ack;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	int lat;
	int qual_seen = 0;
	int ce_seen = 0;

	always #50 sys_clk_i = ~sys_clk_i;

	// pulses counted mid-cycle, away from the edge that launches them
	always @(negedge sys_clk_i) begin
		if (qual === 1'h1) begin
			qual_seen++;
		end
		if (ce === 1'h1) begin
			ce_seen++;
		end
	end

	dbg_clock_sync dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
		.external_debug_request_i(req), .external_break_input_i(brk), .debug_permit_input_i(permit),
		.core_rst_n_i(core_rst_n), .memory_clock_qualifier_i(memq), .tdo_o(tdo), .tdo_oe_o(oe),
		.returned_test_clock_o(echo), .debug_clock_qualifier_o(qual), .core_clock_enable_o(ce),
		.debug_acknowledge_o(ack));
	tck_agent agent (.sys_clk_i(sys_clk_i), .returned_test_clock_i(echo), .tck_o(tck_i), .tms_o(tms_i),
		.tdi_o(tdi_i));

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask
	task automatic chk(input string what, input int exp, input int got);
		checks++;
		if (got != exp) begin
			num_errors++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic test_done();
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end

	// memory qualifier passes through outside debug, one cycle late
	task automatic t_qualifier();
		memq = 1'h1;
		cyc(2);
		chk1("ce_normal", 1'h1, ce);
		memq = 1'h0;
		cyc(2);
		chk1("ce_normal", 1'h0, ce);
	endtask
	// request or break enters debug in 3 cycles, ack then holds
	task automatic t_enter(input logic use_break);
		int n;
		n = 0;
		req = ~use_break;
		brk = use_break;
		while (ack !== 1'h1 && n < 10) begin
			cyc(1);
			n++;
		end
		chk("ack_delay", 3, n);
		req = 1'h0;
		brk = 1'h0;
		memq = 1'h1;
		cyc(6);
		chk1("ack_hold", 1'h1, ack);
		chk1("ce_debug", 1'h0, ce);
		memq = 1'h0;
	endtask
	// tap reset, shift restart code into IR, then idle leaves debug
	task automatic t_restart();
		logic [15:0] tms_seq;
		logic [15:0] tdi_seq;
		logic [15:0] oe_seq;
		int q0;
		int c0;
		q0 = qual_seen;
		c0 = ce_seen;
		tms_seq = 16'h60df;
		tdi_seq = 16'h1000;
		oe_seq = 16'h1e00;
		for (int i = 0; i < 16; i++) begin
			agent.step(tms_seq[i], tdi_seq[i], lat);
			chk("echo_delay", 3, lat);
			chk1("tdo_enable", oe_seq[i], oe);
			if (oe_seq[i]) begin
				chk1("tdo", i == 9, tdo);
			end
			chk1("ack_restart", i != 15, ack);
		end
		// one qualifier per echoed rise; core steps on all but the restarting one
		chk("qual_pulses", 16, qual_seen - q0);
		chk("ce_pulses", 15, ce_seen - c0);
	endtask
	// permit low outside debug: a request is ignored and not remembered
	task automatic t_permit();
		permit = 1'h0;
		cyc(4);
		req = 1'h1;
		cyc(6);
		chk1("ack_ignored", 1'h0, ack);
		req = 1'h0;
		cyc(4);
		permit = 1'h1;
		cyc(6);
		chk1("ack_not_latched", 1'h0, ack);
	endtask
	// permit low inside debug forces ack low; debug state itself survives
	task automatic t_permit_debug();
		permit = 1'h0;
		cyc(4);
		chk1("ack_permit", 1'h0, ack);
		permit = 1'h1;
		cyc(4);
		chk1("ack_permit_back", 1'h1, ack);
	endtask
	// core reset clears debug silently, link keeps running
	task automatic t_core_reset();
		core_rst_n = 1'h0;
		cyc(3);
		core_rst_n = 1'h1;
		cyc(4);
		chk1("ack_core_rst", 1'h0, ack);
		agent.step(1'h1, 1'h0, lat);
		chk("echo_after_rst", 3, lat);
	endtask

	initial begin
		cyc(3);
		rst_i = 1'h0;
		cyc(3);
		chk1("ack_reset", 1'h0, ack);
		t_qualifier();
		t_enter(1'h0);
		t_restart();
		t_permit();
		t_enter(1'h1);
		t_permit_debug();
		t_core_reset();
		test_done();
	end
endmodule
